// ===== hdl/mdpwm_clkgen.sv
// mdpwm_clkgen.sv - source select and divider making the modulator tick
`timescale 1ns/1ps
`default_nettype none
module mdpwm_clkgen (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // configuration
    input  wire logic       restart,
    input  wire logic [1:0] src_sel,
    input  wire logic [1:0] div_sel,
    // clock sources
    input  wire logic       crystal_tick,
    input  wire logic       vco_tick,
    input  wire logic       ext_clk_pin,
    // modulator enables
    output logic            tick,
    output logic            half_tick
);
    // all state of the generator
    typedef struct packed {
        logic       sync0;
        logic       sync1;
        logic       prev;
        logic [3:0] xdiv;
        logic [5:0] pre;
        logic       tick;
        logic       half;
    } mdpwm_cg_state_t;

    mdpwm_cg_state_t s;        // registered state
    mdpwm_cg_state_t n;        // next state
    logic            src_tick; // one pulse per source clock
    logic [5:0]      last;     // prescaler end count

    // source select, crystal/15 and prescaler
    always_comb begin
        n = s;
        last = mdpwm_pkg::div_last(div_sel);
        n.sync0 = ext_clk_pin;
        n.sync1 = s.sync0;
        n.prev = s.sync1;
        // crystal divided by fifteen
        if (crystal_tick) begin
            n.xdiv = (s.xdiv == mdpwm_pkg::XTAL_LAST) ? 4'h0 : s.xdiv + 4'h1;
        end
        // pick the source
        unique case (mdpwm_pkg::mdpwm_src_t'(src_sel))
            mdpwm_pkg::SRC_XTAL15: src_tick = crystal_tick && (s.xdiv == mdpwm_pkg::XTAL_LAST);
            mdpwm_pkg::SRC_XTAL:   src_tick = crystal_tick;
            mdpwm_pkg::SRC_EXT:    src_tick = s.sync1 && !s.prev;
            mdpwm_pkg::SRC_VCO:    src_tick = vco_tick;
        endcase
        n.tick = 1'b0;
        // undivided: half point is the cycle after the tick
        n.half = (last == 6'h00) ? s.tick : 1'b0;
        if (restart) begin
            // control write restarts the divider
            n.pre = 6'h00;
            n.half = 1'b0;
        end else if (src_tick) begin
            n.tick = (s.pre == last);
            n.pre = n.tick ? 6'h00 : s.pre + 6'h01;
            if ((last != 6'h00) && (s.pre == (last >> 1))) begin
                n.half = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tick = s.tick;
    assign half_tick = s.half;
endmodule
`default_nettype wire

// ===== hdl/mdpwm_pkg.sv
// mdpwm_pkg.sv - constants, types and helpers of the dual-output modulator
package mdpwm_pkg;

    // bus geometry: byte address is four times the register index
    localparam int          AXI_ADDR_W = 10;

    // register indexes
    localparam logic [7:0]  IDX_CTRL   = 8'hAE;
    localparam logic [7:0]  IDX_FVL    = 8'hB1;
    localparam logic [7:0]  IDX_FVH    = 8'hB2;
    localparam logic [7:0]  IDX_SVL    = 8'hB3;
    localparam logic [7:0]  IDX_SVH    = 8'hB4;
    localparam logic [7:0]  IDX_STATUS = 8'hB8;

    // reset value of every byte register
    localparam logic [7:0]  RST_BYTE   = 8'h00;

    // control field positions
    localparam int          MODE_LSB   = 4;
    localparam int          DIV_LSB    = 2;
    localparam int          SRC_LSB    = 0;

    // timing counts
    localparam logic [3:0]  XTAL_LAST  = 4'hE;
    localparam logic [15:0] CNT_FULL   = 16'hFFFF;

    // bus responses
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // clock sources
    typedef enum logic [1:0] {
        SRC_XTAL15, SRC_XTAL, SRC_EXT, SRC_VCO
    } mdpwm_src_t;

    // operating modes
    typedef enum logic [2:0] {
        MODE_OFF, MODE_SINGLE16, MODE_TWIN8, MODE_TWIN16,
        MODE_DENS16, MODE_DUAL8, MODE_DENSRZ, MODE_HOLD
    } mdpwm_mode_t;

    // one output pin: level and enable
    typedef struct packed {
        logic level;
        logic oe;
    } mdpwm_pin_t;

    // last prescaler count for a divider code
    function automatic logic [5:0] div_last(input logic [1:0] code);
        case (code)
            2'h0:    div_last = 6'h00;
            2'h1:    div_last = 6'h03;
            2'h2:    div_last = 6'h0F;
            default: div_last = 6'h3F;
        endcase
    endfunction

    // modes whose values are 16 bits wide
    function automatic logic is_wide(input mdpwm_mode_t m);
        is_wide = (m == MODE_SINGLE16) || (m == MODE_TWIN16) ||
                  (m == MODE_DENS16) || (m == MODE_DENSRZ);
    endfunction

endpackage

// ===== hdl/mdpwm_top.sv
// mdpwm_top.sv - dual-output modulator with its register slave
`timescale 1ns/1ps
`default_nettype none
module mdpwm_top (
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // write address channel
    input  wire logic [9:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // write data channel
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // write response channel
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // read address channel
    input  wire logic [9:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // read data channel
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // clock sources
    input  wire logic                  crystal_clock_tick,
    input  wire logic                  pll_vco_clock_tick,
    input  wire logic                  external_clock_pin,
    // output pins
    output mdpwm_pkg::mdpwm_pin_t      first_output_pin,
    output mdpwm_pkg::mdpwm_pin_t      second_output_pin
);
    // all state of the block
    typedef struct packed {
        logic                  aw_pend;
        logic [9:0]            awaddr;
        logic                  w_pend;
        logic [7:0]            wdata;
        logic                  wstb;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [1:0]            rresp;
        logic [31:0]           rdata;
        logic [6:0]            ctrl;
        logic [7:0]            fvl;
        logic [7:0]            fvh;
        logic [7:0]            svl;
        logic [7:0]            svh;
        logic [7:0]            stage0;
        logic [7:0]            stage1;
        logic [15:0]           act0;
        logic [15:0]           act1;
        logic [15:0]           cnt;
        logic [15:0]           acc0;
        logic [15:0]           acc1;
        logic                  out0;
        logic                  out1;
        logic                  rz;
        mdpwm_pkg::mdpwm_pin_t pin0;
        mdpwm_pkg::mdpwm_pin_t pin1;
    } mdpwm_state_t;

    mdpwm_state_t           s;        // registered state
    mdpwm_state_t           n;        // next state
    logic                   wr_do;    // both write halves present
    logic                   ctrl_wr;  // control register written
    logic [7:0]             wr_idx;   // register index of the write
    logic [7:0]             rd_idx;   // register index of the read
    logic                   tick;     // divided modulator tick
    logic                   half;     // middle of a tick period
    mdpwm_pkg::mdpwm_mode_t cur_mode; // mode now in force
    mdpwm_pkg::mdpwm_mode_t m;        // mode after this edge
    logic                   load;     // a new cycle begins
    logic                   eval;     // outputs are re-evaluated
    logic                   wrap_lo;  // low counter byte wraps
    logic                   wrap_hi;  // high counter byte wraps
    logic [15:0]            nc;       // next counter value
    logic [16:0]            sum0;     // first density accumulator sum
    logic [16:0]            sum1;     // second density accumulator sum
    logic                   drive0;   // first pin driven
    logic                   drive1;   // second pin driven

    assign cur_mode = mdpwm_pkg::mdpwm_mode_t'(s.ctrl[6:mdpwm_pkg::MODE_LSB]);

    // tick source and divider, restarted by a control write
    mdpwm_clkgen u_clkgen (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .restart      (ctrl_wr),
        .src_sel      (s.ctrl[mdpwm_pkg::SRC_LSB +: 2]),
        .div_sel      (s.ctrl[mdpwm_pkg::DIV_LSB +: 2]),
        .crystal_tick (crystal_clock_tick),
        .vco_tick     (pll_vco_clock_tick),
        .ext_clk_pin  (external_clock_pin),
        .tick         (tick),
        .half_tick    (half)
    );

    // channel readiness: one write and one read at a time
    assign s_axi_awready = !s.aw_pend;
    assign s_axi_wready = !s.w_pend;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rdata = s.rdata;
    assign first_output_pin = s.pin0;
    assign second_output_pin = s.pin1;
    assign wr_idx = s.awaddr[9:2];
    assign rd_idx = s_axi_araddr[9:2];

    // bus slave, register file and modulator
    always_comb begin
        n = s;
        ctrl_wr = 1'b0;
        load = 1'b0;
        eval = 1'b0;
        wrap_lo = 1'b0;
        wrap_hi = 1'b0;
        nc = s.cnt;
        sum0 = {1'b0, s.acc0};
        sum1 = {1'b0, s.acc1};
        wr_do = s.aw_pend && s.w_pend && !s.bvalid;
        // take address and data in either order
        if (s_axi_awvalid && !s.aw_pend) begin
            n.aw_pend = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s.w_pend) begin
            n.w_pend = 1'b1;
            n.wdata = s_axi_wdata[7:0];
            n.wstb = s_axi_wstrb[0];
        end
        // response handed over
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        // perform a write once both halves are in
        if (wr_do) begin
            n.aw_pend = 1'b0;
            n.w_pend = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = mdpwm_pkg::RESP_OKAY;
            case (wr_idx)
                mdpwm_pkg::IDX_CTRL: begin
                    ctrl_wr = s.wstb;
                    if (s.wstb) begin
                        n.ctrl = s.wdata[6:0];
                    end
                end
                mdpwm_pkg::IDX_FVL: begin
                    if (s.wstb && mdpwm_pkg::is_wide(cur_mode)) begin
                        n.stage0 = s.wdata;
                    end else if (s.wstb) begin
                        n.fvl = s.wdata;
                    end
                end
                mdpwm_pkg::IDX_FVH: begin
                    if (s.wstb) begin
                        n.fvh = s.wdata;
                        if (mdpwm_pkg::is_wide(cur_mode)) begin
                            n.fvl = s.stage0;
                        end
                    end
                end
                mdpwm_pkg::IDX_SVL: begin
                    if (s.wstb && mdpwm_pkg::is_wide(cur_mode)) begin
                        n.stage1 = s.wdata;
                    end else if (s.wstb) begin
                        n.svl = s.wdata;
                    end
                end
                mdpwm_pkg::IDX_SVH: begin
                    if (s.wstb) begin
                        n.svh = s.wdata;
                        if (mdpwm_pkg::is_wide(cur_mode)) begin
                            n.svl = s.stage1;
                        end
                    end
                end
                // status is read only, writes are ignored
                mdpwm_pkg::IDX_STATUS: ;
                default: n.bresp = mdpwm_pkg::RESP_SLVERR;
            endcase
        end
        // read data handed over
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        // take a read and answer next cycle
        if (s_axi_arvalid && !s.rvalid) begin
            n.rvalid = 1'b1;
            n.rresp = mdpwm_pkg::RESP_OKAY;
            case (rd_idx)
                mdpwm_pkg::IDX_CTRL:   n.rdata = {25'h0000000, s.ctrl};
                mdpwm_pkg::IDX_FVL:    n.rdata = {24'h000000, s.fvl};
                mdpwm_pkg::IDX_FVH:    n.rdata = {24'h000000, s.fvh};
                mdpwm_pkg::IDX_SVL:    n.rdata = {24'h000000, s.svl};
                mdpwm_pkg::IDX_SVH:    n.rdata = {24'h000000, s.svh};
                mdpwm_pkg::IDX_STATUS: n.rdata = {14'h0000, s.pin1.level, s.pin0.level, s.cnt};
                default: begin
                    n.rdata = 32'h00000000;
                    n.rresp = mdpwm_pkg::RESP_SLVERR;
                end
            endcase
        end
        m = mdpwm_pkg::mdpwm_mode_t'(n.ctrl[6:mdpwm_pkg::MODE_LSB]);
        if (ctrl_wr) begin
            // restart the cycle from zero
            n.cnt = 16'h0000;
            nc = 16'h0000;
            n.acc0 = 16'h0000;
            n.acc1 = 16'h0000;
            n.out1 = 1'b0;
            n.rz = 1'b0;
            load = 1'b1;
            eval = (m != mdpwm_pkg::MODE_DENS16) && (m != mdpwm_pkg::MODE_DENSRZ);
            n.out0 = 1'b0;
        end else if (tick) begin
            // advance on the divided tick
            unique case (m)
                mdpwm_pkg::MODE_SINGLE16: begin
                    load = (s.cnt == s.act1);
                    nc = load ? 16'h0000 : s.cnt + 16'h0001;
                end
                mdpwm_pkg::MODE_TWIN8: begin
                    load = (s.cnt[7:0] == s.act1[7:0]);
                    nc = load ? 16'h0000 : {8'h00, s.cnt[7:0] + 8'h01};
                end
                mdpwm_pkg::MODE_DUAL8: begin
                    // two byte counters with own periods
                    wrap_lo = (s.cnt[7:0] == s.act1[7:0]);
                    wrap_hi = (s.cnt[15:8] == s.act1[15:8]);
                    nc[7:0] = wrap_lo ? 8'h00 : s.cnt[7:0] + 8'h01;
                    nc[15:8] = wrap_hi ? 8'h00 : s.cnt[15:8] + 8'h01;
                    load = wrap_lo;
                end
                mdpwm_pkg::MODE_TWIN16, mdpwm_pkg::MODE_DENS16, mdpwm_pkg::MODE_DENSRZ: begin
                    load = (s.cnt == mdpwm_pkg::CNT_FULL);
                    nc = s.cnt + 16'h0001;
                end
                // counter held at zero
                mdpwm_pkg::MODE_OFF, mdpwm_pkg::MODE_HOLD: nc = 16'h0000;
            endcase
            n.cnt = nc;
            eval = (m != mdpwm_pkg::MODE_OFF) && (m != mdpwm_pkg::MODE_HOLD);
        end
        // new values only at a cycle start
        if (load) begin
            n.act0 = {s.fvh, s.fvl};
            n.act1 = {s.svh, s.svl};
        end
        if (eval) begin
            unique case (m)
                // high from rollover until the match
                mdpwm_pkg::MODE_SINGLE16, mdpwm_pkg::MODE_TWIN16: begin
                    n.out0 = nc < n.act0;
                    n.out1 = (m == mdpwm_pkg::MODE_TWIN16) && (nc < n.act1);
                end
                mdpwm_pkg::MODE_TWIN8: begin
                    n.out0 = nc[7:0] < n.act0[7:0];
                    if (nc[7:0] == n.act1[15:8]) begin
                        n.out1 = 1'b1;
                    end else if (nc[7:0] == n.act0[15:8]) begin
                        n.out1 = 1'b0;
                    end
                end
                mdpwm_pkg::MODE_DUAL8: begin
                    n.out0 = nc[7:0] < n.act0[7:0];
                    n.out1 = nc[15:8] < n.act0[15:8];
                end
                // carry of a 16-bit accumulator gives pulse density
                mdpwm_pkg::MODE_DENS16, mdpwm_pkg::MODE_DENSRZ: begin
                    sum0 = {1'b0, s.acc0} + {1'b0, n.act0};
                    sum1 = {1'b0, s.acc1} + {1'b0, n.act1};
                    n.acc0 = sum0[15:0];
                    n.acc1 = sum1[15:0];
                    n.out0 = sum0[16];
                    n.out1 = sum1[16];
                    n.rz = 1'b1;
                end
                mdpwm_pkg::MODE_OFF, mdpwm_pkg::MODE_HOLD: ;
            endcase
        end else if (half) begin
            n.rz = 1'b0;
        end
        // pin drive, both released in modes 0 and 7, second pin also released in mode 1
        drive0 = (m != mdpwm_pkg::MODE_OFF) && (m != mdpwm_pkg::MODE_HOLD);
        drive1 = drive0 && (m != mdpwm_pkg::MODE_SINGLE16);
        n.pin0.oe = drive0;
        n.pin1.oe = drive1;
        n.pin0.level = drive0 && n.out0 && ((m != mdpwm_pkg::MODE_DENSRZ) || n.rz);
        n.pin1.level = drive1 && n.out1 && ((m != mdpwm_pkg::MODE_DENSRZ) || n.rz);
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // a control register write taking effect
    sequence s_ctrl_write;
        ctrl_wr;
    endsequence

    // a mode 3 rollover with both values non-zero
    sequence s_twin16_roll;
        tick && !ctrl_wr && (cur_mode == mdpwm_pkg::MODE_TWIN16) && (s.cnt == mdpwm_pkg::CNT_FULL)
            && ({s.fvh, s.fvl} != 16'h0000) && ({s.svh, s.svl} != 16'h0000);
    endsequence

    a_ctrl_clears_cnt: assert property (s_ctrl_write |=> (s.cnt == 16'h0000))
        else $error("counter not cleared by control write");
    a_low_byte_staged: assert property (wr_do && s.wstb && (wr_idx == mdpwm_pkg::IDX_FVL)
        && mdpwm_pkg::is_wide(cur_mode) |=> $stable(s.fvl) && (s.stage0 == $past(s.wdata)))
        else $error("low byte not staged");
    a_act_midcycle: assert property (!ctrl_wr && !(tick && (s.cnt == s.act1))
        && (cur_mode == mdpwm_pkg::MODE_SINGLE16) |=> $stable(s.act0))
        else $error("active value changed mid cycle");
    a_off_released: assert property ((cur_mode == mdpwm_pkg::MODE_OFF) && !ctrl_wr
        |=> !first_output_pin.oe && !second_output_pin.oe)
        else $error("pins driven in mode 0");
    a_hold_mode: assert property ((cur_mode == mdpwm_pkg::MODE_HOLD) && !ctrl_wr
        |=> (s.cnt == 16'h0000) && !first_output_pin.oe && !second_output_pin.oe)
        else $error("mode 7 not holding");
    a_period_wrap: assert property (tick && !ctrl_wr && (cur_mode == mdpwm_pkg::MODE_SINGLE16)
        && (s.cnt == s.act1) |=> (s.cnt == 16'h0000))
        else $error("mode 1 period wrap missed");
    a_twin16_sync: assert property (s_twin16_roll |=> first_output_pin.level
        && second_output_pin.level)
        else $error("mode 3 outputs not high together");
    a_count_step: assert property (tick && !ctrl_wr && (cur_mode == mdpwm_pkg::MODE_TWIN16)
        |=> (s.cnt == $past(s.cnt) + 16'h0001))
        else $error("counter did not step by one");
    a_twin8_start: assert property (tick && !ctrl_wr && (cur_mode == mdpwm_pkg::MODE_TWIN8)
        && (s.cnt[7:0] == s.act1[7:0]) && (s.fvl != 8'h00) |=> first_output_pin.level)
        else $error("mode 2 first pin not high at cycle start");
    a_rz_half: assert property (half && !tick && !ctrl_wr && (cur_mode == mdpwm_pkg::MODE_DENSRZ)
        |=> !first_output_pin.level && !second_output_pin.level)
        else $error("return-to-zero half missing");
endmodule
`default_nettype wire

// ===== sim/mdpwm_load.sv
// mdpwm_load.sv - load on the two output pins, counting driven-high cycles
`timescale 1ns/1ps
`default_nettype none
module mdpwm_load (
    // clock and control
    input  wire logic                  aclk,
    input  wire logic                  clr,
    // pins from the modulator
    input  wire mdpwm_pkg::mdpwm_pin_t pin_a,
    input  wire mdpwm_pkg::mdpwm_pin_t pin_b,
    // driven-high cycle counts
    output logic [31:0]                cnt_a,
    output logic [31:0]                cnt_b
);
    logic tog = 1'b0; // filler pattern for released lines
    logic wire_a;     // resolved line levels
    logic wire_b;
    // a released line shows a changing pattern, never its last level
    assign wire_a = pin_a.oe ? pin_a.level : tog;
    assign wire_b = pin_b.oe ? pin_b.level : tog;
    // count only cycles in which the modulator drives a line high
    always_ff @(posedge aclk) begin
        tog   <= ~tog;
        cnt_a <= clr ? 32'h0 : cnt_a + 32'(wire_a & pin_a.oe);
        cnt_b <= clr ? 32'h0 : cnt_b + 32'(wire_b & pin_b.oe);
    end
endmodule
`default_nettype wire

// ===== sim/multimode_dual_pwm_tb.sv
// multimode_dual_pwm_tb.sv - self-checking bench of the dual-output modulator
`timescale 1ns/1ps
`default_nettype none
module multimode_dual_pwm_tb;
    logic                  aclk = 1'b0;    // bus clock
    logic                  aresetn = 1'b0; // reset, active low
    logic [9:0]            aw = 10'h0;     // master side of the bus
    logic [9:0]            ar = 10'h0;
    logic [31:0]           wd = 32'h0;
    logic                  awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic                  clr = 1'b0, ctk = 1'b0, ext = 1'b0; // load clear, clock sources
    logic [2:0]            ph = 3'h0;      // source pattern phase
    logic                  awr, wrd, bv, arr, rv;
    logic [1:0]            br, rr;
    logic [31:0]           rd, c1, c2;
    mdpwm_pkg::mdpwm_pin_t p1, p2;
    int                    error_cnt = 0;
    int                    n_tests = 0;
    // clock and crystal / external pin patterns (crystal every 2, pin every 8)
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        ph  <= ph + 3'h1;
        ctk <= ph[0];
        ext <= ph[2];
    end
    mdpwm_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .crystal_clock_tick(ctk),
        .pll_vco_clock_tick(1'b1), .external_clock_pin(ext), .first_output_pin(p1),
        .second_output_pin(p2));
    mdpwm_load u_load (.aclk(aclk), .clr(clr), .pin_a(p1), .pin_b(p2), .cnt_a(c1), .cnt_b(c2));
    // compare and count
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // one bus write; address and data offered together, each released when taken
    task wr(input logic [7:0] i, input logic [7:0] d, output logic [1:0] r);
        @(posedge aclk);
        aw <= {i, 2'h0}; wd <= {24'h0, d}; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
        for (int k = 0; k < 100; k++) begin
            @(posedge aclk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrd) wv <= 1'b0;
            if (bv) begin r = br; bry <= 1'b0; break; end
        end
    endtask
    // one bus read
    task rdr(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        ar <= {i, 2'h0}; arv <= 1'b1; rry <= 1'b1;
        for (int k = 0; k < 100; k++) begin
            @(posedge aclk);
            if (arv && arr) arv <= 1'b0;
            if (rv) begin d = rd; r = rr; rry <= 1'b0; break; end
        end
    endtask
    // write expecting an okay answer
    task w(input logic [7:0] i, input logic [7:0] d);
        logic [1:0] r;
        wr(i, d, r);
        chk(32'(r), 32'(mdpwm_pkg::RESP_OKAY));
    endtask
    // wait a tenth of the window, then count driven-high cycles over a window of n cycles
    task meas(input int n, input int e1, input int e2);
        repeat (n / 10) @(posedge aclk);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (n) @(posedge aclk);
        @(negedge aclk);
        chk(c1, e1);
        chk(c2, e2);
    endtask
    // load both values under mode pre, restart with ctrl, then measure
    task run(input logic [7:0] pre, input logic [7:0] ctrl, input logic [15:0] fv,
             input logic [15:0] sv, input int n, input int e1, input int e2);
        w(mdpwm_pkg::IDX_CTRL, pre);
        w(mdpwm_pkg::IDX_FVL, fv[7:0]);
        w(mdpwm_pkg::IDX_FVH, fv[15:8]);
        w(mdpwm_pkg::IDX_SVL, sv[7:0]);
        w(mdpwm_pkg::IDX_SVH, sv[15:8]);
        w(mdpwm_pkg::IDX_CTRL, ctrl);
        meas(n, e1, e2);
    endtask
    // reset values, unmapped places, released pins
    task t_reset;
        logic [7:0]  idx [5];
        logic [31:0] d;
        logic [1:0]  r;
        idx = '{mdpwm_pkg::IDX_CTRL, mdpwm_pkg::IDX_FVL, mdpwm_pkg::IDX_FVH,
                mdpwm_pkg::IDX_SVL, mdpwm_pkg::IDX_SVH};
        foreach (idx[k]) begin
            rdr(idx[k], d, r);
            chk(d, 32'h0);
        end
        rdr(8'h00, d, r);
        chk(32'(r), 32'(mdpwm_pkg::RESP_SLVERR));
        wr(8'h00, 8'h5A, r);
        chk(32'(r), 32'(mdpwm_pkg::RESP_SLVERR));
        chk(32'({p1.oe, p2.oe}), 32'h0);
    endtask
    // twin 8-bit mode over every divider code
    task t_mode2;
        for (int d = 0; d < 4; d++) begin
            run(8'h00, {4'h2, 2'(d), 2'h3}, 16'h0703, 16'h0209, 100 << 2 * d, 30 << 2 * d, 50 << 2 * d);
        end
    endtask
    // the other clock sources: crystal, crystal/15, external pin
    task t_src;
        run(8'h00, 8'h21, 16'h0703, 16'h0209, 200, 60, 100);
        run(8'h00, 8'h20, 16'h0703, 16'h0209, 3000, 900, 1500);
        run(8'h00, 8'h22, 16'h0703, 16'h0209, 800, 240, 400);
    endtask
    // single output with programmable period, then the staged low byte
    task t_mode1;
        logic [31:0] d;
        logic [1:0]  r;
        run(8'h13, 8'h13, 16'h0005, 16'h0013, 100, 25, 0);
        w(mdpwm_pkg::IDX_SVL, 8'h55);
        rdr(mdpwm_pkg::IDX_SVL, d, r);
        chk(d, 32'h13);
        w(mdpwm_pkg::IDX_SVH, 8'h00);
        rdr(mdpwm_pkg::IDX_SVL, d, r);
        chk(d, 32'h55);
    endtask
    // twin 16-bit: pins high from restart until their matches, then low
    task t_mode3;
        run(8'h33, 8'h33, 16'h0003, 16'h0005, 100, 0, 0);
        @(posedge aclk);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        w(mdpwm_pkg::IDX_CTRL, 8'h33);
        repeat (20) @(posedge aclk);
        @(negedge aclk);
        // count zero stands one extra cycle after the restart
        chk(c1, 32'h4);
        chk(c2, 32'h6);
    endtask
    // pulse density, plain and return-to-zero, divider 4
    task t_dens;
        run(8'h43, 8'h47, 16'h4000, 16'h8000, 1600, 400, 800);
        run(8'h63, 8'h67, 16'h4000, 16'h8000, 1600, 200, 400);
    endtask
    // dual 8-bit with separate periods
    task t_mode5;
        run(8'h00, 8'h53, 16'h0203, 16'h0409, 100, 30, 40);
    endtask
    // counter held and pins released in mode 7, released again in mode 0
    task t_hold;
        logic [31:0] d;
        logic [1:0]  r;
        w(mdpwm_pkg::IDX_CTRL, 8'h73);
        repeat (20) @(posedge aclk);
        chk(32'({p1.oe, p2.oe}), 32'h0);
        rdr(mdpwm_pkg::IDX_STATUS, d, r);
        chk({16'h0, d[15:0]}, 32'h0);
        w(mdpwm_pkg::IDX_CTRL, 8'h00);
        chk(32'({p1.oe, p2.oe}), 32'h0);
    endtask
    // verdict and end of run
    task test_done;
        $display("errors %0d comparisons %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_mode2;
        t_src;
        t_mode1;
        t_mode3;
        t_dens;
        t_mode5;
        t_hold;
        test_done;
    end
    // watchdog against a hang
    initial begin
        repeat (40000) @(posedge aclk);
        error_cnt++;
        test_done;
    end
endmodule
`default_nettype wire
